//--- shared/fcr_params.svh
// register offsets, reset values and timing counts of the front-end configuration bank
`ifndef FCR_PARAMS_SVH
`define FCR_PARAMS_SVH
`define FCR_OFS_INIT        8'h00
`define FCR_OFS_VIDEO       8'h07
`define FCR_OFS_CONV_CLK    8'h08
`define FCR_OFS_SPARE_A     8'h09
`define FCR_OFS_SPARE_B     8'h0a
`define FCR_OFS_SPARE_C     8'h0b
`define FCR_OFS_VERSION     8'h0c
`define FCR_OFS_TW_LOW      8'h0d
`define FCR_OFS_FINE_GAIN   8'h0e
`define FCR_OFS_TX_PATH     8'h0f
`define FCR_OFS_P0_TW0      8'h10
`define FCR_OFS_P0_TW1      8'h11
`define FCR_OFS_P0_TW2      8'h12
`define FCR_OFS_P0_GAIN     8'h13
`define FCR_OFS_P1_TW0      8'h14
`define FCR_OFS_P1_TW1      8'h15
`define FCR_OFS_P1_TW2      8'h16
`define FCR_OFS_P1_GAIN     8'h17
`define FCR_MULT_RST        5'h08
`define FCR_MULT_BYPASS     5'h01
`define FCR_INIT_SRST_BIT   5
`define FCR_INIT_LSB_BIT    6
`define FCR_CONV_CLK_RST    8'h80
`define FCR_VIDEO_RST       8'h00
`define FCR_SPARE_RST       8'h00
`define FCR_TW_LOW_RST      8'h00
`define FCR_FINE_GAIN_RST   8'h00
`define FCR_TX_PATH_RST     8'h00
`define FCR_TUNING_RST      8'h00
`define FCR_GAIN_RST        8'h00
`define FCR_TX_PROFILE_BIT  5
`define FCR_LOCK_CYCLES     200
`endif

//--- shared/fcr_pkg.sv
// types of the front-end configuration bank
package fcr_pkg;
  typedef enum logic [3:0] {
    FCR_IDLE  = 4'b0001,
    FCR_INSTR = 4'b0010,
    FCR_WDATA = 4'b0100,
    FCR_RDATA = 4'b1000
  } fcr_state_t;

  typedef struct packed {
    logic [7:0] init;
    logic [7:0] video;
    logic [7:0] conv_clk;
    logic [7:0] spare_a;
    logic [7:0] spare_b;
    logic [7:0] spare_c;
    logic [7:0] tw_low;
    logic [7:0] fine_gain;
    logic [7:0] tx_path;
    logic [7:0] p0_tw0;
    logic [7:0] p0_tw1;
    logic [7:0] p0_tw2;
    logic [7:0] p0_gain;
    logic [7:0] p1_tw0;
    logic [7:0] p1_tw1;
    logic [7:0] p1_tw2;
    logic [7:0] p1_gain;
  } fcr_regs_t;

  typedef struct packed {
    logic [25:0] tuning_word;
    logic [3:0]  coarse_gain;
    logic [3:0]  fine_gain;
  } fcr_profile_t;
endpackage

//--- verilog/fcr_bank.sv
// configuration register bank with serial port, clock multiplier status and profiles
`timescale 1ns/1ps
`include "fcr_params.svh"

module fcr_bank #(
  parameter int          LOCK_CYCLES = `FCR_LOCK_CYCLES,
  parameter logic [7:0]  DIE_VERSION = 8'h01   // value arbitrary
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 reset_pin_n,
  input  wire logic                 sport_cs_n,
  input  wire logic                 sport_sclk,
  input  wire logic                 sport_sdi,
  output logic                      sport_sdo,
  output logic                      sport_sdo_oe_n,
  output logic [4:0]                clock_multiplier,
  output logic                      pll_bypass,
  output logic                      sysclk_stable,
  output logic                      chip_restart,
  output logic                      lsb_first,
  output logic                      sdio_bidir,
  output logic [7:0]                video_input_config,
  output logic [7:0]                converter_clock_config,
  output logic [7:0]                transmit_path_config,
  output logic [3:0]                output_fine_gain,
  output logic                      active_profile,
  output fcr_pkg::fcr_profile_t     profile0,
  output fcr_pkg::fcr_profile_t     profile1
);

  typedef struct packed {
    logic [1:0]          rst_sync;
    logic [2:0]          cs_sync;
    logic [2:0]          sclk_sync;
    logic [1:0]          sdi_sync;
    fcr_pkg::fcr_state_t state;
    logic [2:0]          bit_cnt;
    logic [7:0]          shift;
    logic                rd;
    logic [7:0]          addr;
    fcr_pkg::fcr_regs_t  regs;
    logic [8:0]          lock_cnt;
    logic                sdo;
    logic                sdo_oe_n;
    logic                restart;
    logic                bypass;
    logic                stable;
    fcr_pkg::fcr_profile_t p0;
    fcr_pkg::fcr_profile_t p1;
  } fcr_core_t;

  localparam logic [8:0] LOCK_LAST = 9'(LOCK_CYCLES - 1);

  fcr_core_t cur_ff;
  fcr_core_t nxt_st;

  function automatic fcr_pkg::fcr_regs_t defaults(input logic [7:0] init_val);
    fcr_pkg::fcr_regs_t r;
    r.init      = init_val;
    r.video     = `FCR_VIDEO_RST;
    r.conv_clk  = `FCR_CONV_CLK_RST;
    r.spare_a   = `FCR_SPARE_RST;
    r.spare_b   = `FCR_SPARE_RST;
    r.spare_c   = `FCR_SPARE_RST;
    r.tw_low    = `FCR_TW_LOW_RST;
    r.fine_gain = `FCR_FINE_GAIN_RST;
    r.tx_path   = `FCR_TX_PATH_RST;
    r.p0_tw0    = `FCR_TUNING_RST;
    r.p0_tw1    = `FCR_TUNING_RST;
    r.p0_tw2    = `FCR_TUNING_RST;
    r.p0_gain   = `FCR_GAIN_RST;
    r.p1_tw0    = `FCR_TUNING_RST;
    r.p1_tw1    = `FCR_TUNING_RST;
    r.p1_tw2    = `FCR_TUNING_RST;
    r.p1_gain   = `FCR_GAIN_RST;
    return r;
  endfunction

  function automatic logic [7:0] read_reg(input fcr_pkg::fcr_regs_t r, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `FCR_OFS_INIT:      v = {r.init[7:6], 1'b0, r.init[4:0]};
      `FCR_OFS_VIDEO:     v = r.video;
      `FCR_OFS_CONV_CLK:  v = r.conv_clk;
      `FCR_OFS_SPARE_A:   v = r.spare_a;
      `FCR_OFS_SPARE_B:   v = r.spare_b;
      `FCR_OFS_SPARE_C:   v = r.spare_c;
      `FCR_OFS_VERSION:   v = DIE_VERSION;
      `FCR_OFS_TW_LOW:    v = r.tw_low;
      `FCR_OFS_FINE_GAIN: v = r.fine_gain;
      `FCR_OFS_TX_PATH:   v = r.tx_path;
      `FCR_OFS_P0_TW0:    v = r.p0_tw0;
      `FCR_OFS_P0_TW1:    v = r.p0_tw1;
      `FCR_OFS_P0_TW2:    v = r.p0_tw2;
      `FCR_OFS_P0_GAIN:   v = r.p0_gain;
      `FCR_OFS_P1_TW0:    v = r.p1_tw0;
      `FCR_OFS_P1_TW1:    v = r.p1_tw1;
      `FCR_OFS_P1_TW2:    v = r.p1_tw2;
      `FCR_OFS_P1_GAIN:   v = r.p1_gain;
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic       cs_start;
  logic [7:0] shifted;
  logic       sb;

  // per-profile views of the held bytes
  logic [7:0]            prof_tw0  [2];
  logic [7:0]            prof_tw1  [2];
  logic [7:0]            prof_tw2  [2];
  logic [7:0]            prof_gain [2];
  logic [1:0]            prof_lsb  [2];
  fcr_pkg::fcr_profile_t prof_asm  [2];

  assign prof_tw0[0]  = cur_ff.regs.p0_tw0;
  assign prof_tw1[0]  = cur_ff.regs.p0_tw1;
  assign prof_tw2[0]  = cur_ff.regs.p0_tw2;
  assign prof_gain[0] = cur_ff.regs.p0_gain;
  assign prof_lsb[0]  = cur_ff.regs.tw_low[1:0];
  assign prof_tw0[1]  = cur_ff.regs.p1_tw0;
  assign prof_tw1[1]  = cur_ff.regs.p1_tw1;
  assign prof_tw2[1]  = cur_ff.regs.p1_tw2;
  assign prof_gain[1] = cur_ff.regs.p1_gain;
  assign prof_lsb[1]  = cur_ff.regs.tw_low[3:2];

  // gain byte: coarse nibble above fine nibble
  for (genvar p = 0; p < 2; p++) begin : g_prof
    assign prof_asm[p] = {prof_tw2[p], prof_tw1[p], prof_tw0[p], prof_lsb[p],
                          prof_gain[p]};
  end

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.rst_sync  = {cur_ff.rst_sync[0], ~reset_pin_n};
    nxt_st.cs_sync   = {cur_ff.cs_sync[1:0], ~sport_cs_n};
    nxt_st.sclk_sync = {cur_ff.sclk_sync[1:0], sport_sclk};
    nxt_st.sdi_sync  = {cur_ff.sdi_sync[0], sport_sdi};
    nxt_st.restart   = 1'b0;
    sclk_rise = cur_ff.sclk_sync[1] & ~cur_ff.sclk_sync[2];
    sclk_fall = ~cur_ff.sclk_sync[1] & cur_ff.sclk_sync[2];
    cs_act    = cur_ff.cs_sync[1];
    cs_start  = cur_ff.cs_sync[1] & ~cur_ff.cs_sync[2];
    // new bits enter at the end matching the transfer order
    shifted = cur_ff.regs.init[`FCR_INIT_LSB_BIT]
            ? {cur_ff.sdi_sync[1], cur_ff.shift[7:1]}
            : {cur_ff.shift[6:0], cur_ff.sdi_sync[1]};
    sb    = cur_ff.regs.init[`FCR_INIT_LSB_BIT] ? cur_ff.shift[0] : cur_ff.shift[7];

    if (!cs_act) begin
      nxt_st.state    = fcr_pkg::FCR_IDLE;
      nxt_st.sdo_oe_n = 1'b1;
    end else begin
      case (cur_ff.state)
        fcr_pkg::FCR_IDLE: begin
          if (cs_start) begin
            nxt_st.state   = fcr_pkg::FCR_INSTR;
            nxt_st.bit_cnt = 3'd0;
          end
        end
        fcr_pkg::FCR_INSTR: begin
          if (sclk_rise) begin
            nxt_st.shift   = shifted;
            nxt_st.bit_cnt = cur_ff.bit_cnt + 3'd1;
            if (cur_ff.bit_cnt == 3'd7) begin
              // instruction: read flag in bit 7, register address in low bits
              nxt_st.rd   = shifted[7];
              nxt_st.addr = {3'b000, shifted[4:0]};
              if (shifted[7]) begin
                nxt_st.state = fcr_pkg::FCR_RDATA;
                nxt_st.shift = read_reg(cur_ff.regs, {3'b000, shifted[4:0]});
              end else begin
                nxt_st.state = fcr_pkg::FCR_WDATA;
              end
            end
          end
        end
        fcr_pkg::FCR_WDATA: begin
          if (sclk_rise) begin
            nxt_st.shift   = shifted;
            nxt_st.bit_cnt = cur_ff.bit_cnt + 3'd1;
            if (cur_ff.bit_cnt == 3'd7) begin
              nxt_st.state = fcr_pkg::FCR_IDLE;
              case (cur_ff.addr)
                `FCR_OFS_INIT: begin
                  if (shifted[`FCR_INIT_SRST_BIT]) begin
                    // software reset spares initialization_control entirely
                    nxt_st.regs    = defaults(cur_ff.regs.init);
                    nxt_st.restart = 1'b1;
                  end else begin
                    nxt_st.regs.init = {shifted[7:6], 1'b0, shifted[4:0]};
                  end
                end
                `FCR_OFS_VIDEO:     nxt_st.regs.video     = shifted;
                `FCR_OFS_CONV_CLK:  nxt_st.regs.conv_clk  = shifted;
                `FCR_OFS_SPARE_A:   nxt_st.regs.spare_a   = shifted;
                `FCR_OFS_SPARE_B:   nxt_st.regs.spare_b   = shifted;
                `FCR_OFS_SPARE_C:   nxt_st.regs.spare_c   = shifted;
                `FCR_OFS_TW_LOW:    nxt_st.regs.tw_low    = shifted;
                `FCR_OFS_FINE_GAIN: nxt_st.regs.fine_gain = shifted;
                `FCR_OFS_TX_PATH:   nxt_st.regs.tx_path   = shifted;
                `FCR_OFS_P0_TW0:    nxt_st.regs.p0_tw0    = shifted;
                `FCR_OFS_P0_TW1:    nxt_st.regs.p0_tw1    = shifted;
                `FCR_OFS_P0_TW2:    nxt_st.regs.p0_tw2    = shifted;
                `FCR_OFS_P0_GAIN:   nxt_st.regs.p0_gain   = shifted;
                `FCR_OFS_P1_TW0:    nxt_st.regs.p1_tw0    = shifted;
                `FCR_OFS_P1_TW1:    nxt_st.regs.p1_tw1    = shifted;
                `FCR_OFS_P1_TW2:    nxt_st.regs.p1_tw2    = shifted;
                `FCR_OFS_P1_GAIN:   nxt_st.regs.p1_gain   = shifted;
                default:            nxt_st.regs           = cur_ff.regs;
              endcase
            end
          end
        end
        fcr_pkg::FCR_RDATA: begin
          if (sclk_fall) begin
            nxt_st.sdo      = sb;
            nxt_st.sdo_oe_n = 1'b0;
          end
          if (sclk_rise) begin
            nxt_st.shift   = cur_ff.regs.init[`FCR_INIT_LSB_BIT]
                           ? {1'b0, cur_ff.shift[7:1]} : {cur_ff.shift[6:0], 1'b0};
            nxt_st.bit_cnt = cur_ff.bit_cnt + 3'd1;
            if (cur_ff.bit_cnt == 3'd7) begin
              nxt_st.state = fcr_pkg::FCR_IDLE;
            end
          end
        end
        default: nxt_st.state = fcr_pkg::FCR_IDLE;
      endcase
    end

    // profile words follow the held bytes, each byte write showing one cycle later
    nxt_st.p0 = prof_asm[0];
    nxt_st.p1 = prof_asm[1];

    if (cur_ff.rst_sync[1]) begin
      nxt_st.regs     = defaults({3'b000, `FCR_MULT_RST});
      nxt_st.state    = fcr_pkg::FCR_IDLE;
      nxt_st.sdo_oe_n = 1'b1;
    end

    // lock timer restarts on any change of the multiplier, pin reset included
    if (nxt_st.regs.init[4:0] != cur_ff.regs.init[4:0]) begin
      nxt_st.lock_cnt = 9'd0;
    end else if (cur_ff.lock_cnt != LOCK_LAST + 9'd1) begin
      nxt_st.lock_cnt = cur_ff.lock_cnt + 9'd1;
    end

    // status outputs taken from flops, free of decode glitches
    nxt_st.bypass = (nxt_st.regs.init[4:0] == `FCR_MULT_BYPASS);
    nxt_st.stable = (nxt_st.lock_cnt == LOCK_LAST + 9'd1);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff            <= '0;
      cur_ff.cs_sync    <= 3'b000;
      cur_ff.sclk_sync  <= 3'b000;
      cur_ff.state      <= fcr_pkg::FCR_IDLE;
      cur_ff.regs.init  <= {3'b000, `FCR_MULT_RST};
      cur_ff.regs.conv_clk <= `FCR_CONV_CLK_RST;
      cur_ff.sdo_oe_n   <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign sport_sdo              = cur_ff.sdo;
  assign sport_sdo_oe_n         = cur_ff.sdo_oe_n;
  assign clock_multiplier       = cur_ff.regs.init[4:0];
  assign pll_bypass             = cur_ff.bypass;
  assign sysclk_stable          = cur_ff.stable;
  assign chip_restart           = cur_ff.restart;
  assign lsb_first              = cur_ff.regs.init[`FCR_INIT_LSB_BIT];
  assign sdio_bidir             = cur_ff.regs.init[7];
  assign video_input_config     = cur_ff.regs.video;
  assign converter_clock_config = cur_ff.regs.conv_clk;
  assign transmit_path_config   = cur_ff.regs.tx_path;
  assign output_fine_gain       = cur_ff.regs.fine_gain[3:0];
  assign active_profile         = cur_ff.regs.tx_path[`FCR_TX_PROFILE_BIT];
  assign profile0               = cur_ff.p0;
  assign profile1               = cur_ff.p1;

endmodule // fcr_bank

//--- testbench/fcr_host.sv
// host model driving frames on the serial configuration port
`timescale 1ns/1ps
module fcr_host (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // instruction byte then one data byte; q collects read data
  task automatic frame(input logic [7:0] ins, input logic [7:0] d, input logic lsb,
                       output logic [7:0] q);
    logic [15:0] w;
    int          k;
    w = {ins, d};
    q = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      k = lsb ? ((i < 8) ? 8 + i : i - 8) : 15 - i;
      sdi = w[k];
      wt(4);
      if (i > 7) q[k] = sdo;
      sclk = 1'b1;
      wt(4);
      sclk = 1'b0;
    end
    wt(8);
    cs_n = 1'b1;
    sdi = ~sdi;
    wt(8);
  endtask
endmodule // fcr_host

//--- testbench/fcr_bank_chk.sv
// port assertions of the configuration register bank
`timescale 1ns/1ps
module fcr_bank_chk #(
  parameter int LOCK_CYCLES = 200
) (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  reset_pin_n,
  input wire logic                  sport_cs_n,
  input wire logic                  sport_sdo_oe_n,
  input wire logic [4:0]            clock_multiplier,
  input wire logic                  pll_bypass,
  input wire logic                  sysclk_stable,
  input wire logic                  chip_restart,
  input wire logic [7:0]            converter_clock_config,
  input wire logic [7:0]            transmit_path_config,
  input wire fcr_pkg::fcr_profile_t profile0,
  input wire fcr_pkg::fcr_profile_t profile1
);
  logic [4:0]  mult_ff;
  logic [15:0] cnt_ff;
  // cycles since the multiplier last changed
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mult_ff <= 5'h08;
      cnt_ff  <= 16'h0000;
    end else begin
      mult_ff <= clock_multiplier;
      cnt_ff  <= (clock_multiplier != mult_ff) ? 16'h0000 : cnt_ff + 16'(cnt_ff != 16'hffff);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_mult_default: assert property ($fell(sys_rst) |-> clock_multiplier == 5'h08)
    else $error("multiplier not at default after reset");
  a_bypass_one: assert property (pll_bypass == (clock_multiplier == 5'h01))
    else $error("bypass does not follow multiplier of one");
  a_change_unlocks: assert property (clock_multiplier != mult_ff |=> !sysclk_stable [*2])
    else $error("clock stable right after multiplier change");
  a_lock_wait: assert property (sysclk_stable |-> cnt_ff >= LOCK_CYCLES - 1)
    else $error("clock stable before lock time");
  a_restart_pulse: assert property (chip_restart |=> !chip_restart)
    else $error("restart longer than one cycle");
  a_restart_clears: assert property (chip_restart |-> ##[0:2]
    (converter_clock_config == 8'h80 && transmit_path_config == 8'h00 && profile1 == '0))
    else $error("registers not default after software reset");
  a_pin_defaults: assert property (!reset_pin_n [*5] |->
    (clock_multiplier == 5'h08 && converter_clock_config == 8'h80 && profile0 == '0))
    else $error("registers not default under reset pin");
  a_oe_idle: assert property (sport_cs_n [*6] |-> sport_sdo_oe_n)
    else $error("serial output driven outside frame");
  a_profile_whole: assert property ($changed(profile0) |=> $stable(profile0) [*3])
    else $error("profile word changed in pieces");
  a_idle_hold: assert property ((sport_cs_n && reset_pin_n) [*8] |->
    ($stable(transmit_path_config) && $stable(profile1)))
    else $error("register changed without access");
endmodule // fcr_bank_chk

bind fcr_bank fcr_bank_chk #(.LOCK_CYCLES(LOCK_CYCLES)) i_fcr_bank_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
  .sport_cs_n(sport_cs_n), .sport_sdo_oe_n(sport_sdo_oe_n),
  .clock_multiplier(clock_multiplier), .pll_bypass(pll_bypass),
  .sysclk_stable(sysclk_stable), .chip_restart(chip_restart),
  .converter_clock_config(converter_clock_config),
  .transmit_path_config(transmit_path_config), .profile0(profile0), .profile1(profile1)
);

//--- testbench/testbench.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] VER = 8'h05; // value arbitrary
  logic                  core_clk, sys_rst, reset_pin_n, cs_n, sclk, sdi, sdo, oe_n;
  logic                  byp, stab, restart, lsbf, bidir, actp;
  logic [4:0]            mult;
  logic [3:0]            fgain;
  logic [7:0]            video, conv, txp;
  fcr_pkg::fcr_profile_t p0, p1;
  wire                   sdo_line;
  logic [7:0]            mdl [0:31];
  logic [4:0]            ms [0:2] = '{5'h01, 5'h1f, 5'h10};
  logic [39:0]           seen, exp_q[$];
  int                    num_errors = 0, checked = 0, restarts = 0, rnd;
  event                  shown;
  assign sdo_line = oe_n ? 1'bz : sdo;
  fcr_bank #(.LOCK_CYCLES(4), .DIE_VERSION(VER)) i_fcr_bank (
    .core_clk(core_clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .sport_cs_n(cs_n),
    .sport_sclk(sclk), .sport_sdi(sdi), .sport_sdo(sdo), .sport_sdo_oe_n(oe_n),
    .clock_multiplier(mult), .pll_bypass(byp), .sysclk_stable(stab), .chip_restart(restart),
    .lsb_first(lsbf), .sdio_bidir(bidir), .video_input_config(video),
    .converter_clock_config(conv), .transmit_path_config(txp), .output_fine_gain(fgain),
    .active_profile(actp), .profile0(p0), .profile1(p1));
  fcr_host i_fcr_host (.clk(core_clk), .sdo(sdo_line), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (restart === 1'b1) restarts++;
  task automatic check(input logic [39:0] s, input logic [39:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  initial forever begin
    @shown;
    check(seen, exp_q.pop_front());
  end
  task automatic chk_port(input logic [39:0] s, input logic [39:0] e);
    exp_q.push_back(e);
    seen = s;
    -> shown;
    #1;
  endtask
  task automatic dflt(input logic all);
    for (int a = 1; a < 32; a++) mdl[a] = 8'h00;
    mdl[8]  = 8'h80;
    mdl[12] = VER;
    if (all) mdl[0] = 8'h08;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_fcr_host.frame({3'b000, a}, d, mdl[0][6], q);
    if (a == 5'h00 && d[5]) dflt(1'b0);
    else if (a == 5'h00 || (a > 5'h06 && a < 5'h18 && a != 5'h0c)) mdl[a] = d;
  endtask
  task automatic rd_all;
    logic [7:0] q;
    for (int a = 0; a < 32; a++) begin
      i_fcr_host.frame({3'b100, 5'(a)}, 8'h00, mdl[0][6], q);
      chk_port(40'(q), 40'(mdl[a]));
    end
  endtask
  task automatic ports;
    chk_port(40'({mult, byp, stab, lsbf, bidir, video, conv, txp, fgain, actp}),
             40'({mdl[0][4:0], mdl[0][4:0] == 5'h01, 1'b1, mdl[0][6], mdl[0][7], mdl[7],
                  mdl[8], mdl[15], mdl[14][3:0], mdl[15][5]}));
    chk_port(40'(p0), 40'({mdl[18], mdl[17], mdl[16], mdl[13][1:0], mdl[19]}));
    chk_port(40'(p1), 40'({mdl[22], mdl[21], mdl[20], mdl[13][3:2], mdl[23]}));
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rnd = $urandom(32'h8bcf_f6fc);
    sys_rst = 1'b1;
    reset_pin_n = 1'b1;
    i_fcr_host.wt(4);
    sys_rst = 1'b0;
    dflt(1'b1);
    i_fcr_host.wt(10);
    ports();
    rd_all();
    for (int a = 7; a < 24; a++) wr(5'(a), 8'($urandom));
    rd_all();
    ports();
    foreach (ms[i]) begin
      wr(5'h00, {3'b000, ms[i]});
      ports();
    end
    wr(5'h00, 8'h4a);
    rd_all();
    wr(5'h00, 8'h08);
    wr(5'h00, 8'he3);
    chk_port(40'(restarts), 40'h01);
    rd_all();
    for (int a = 7; a < 24; a++) wr(5'(a), 8'($urandom));
    wr(5'h00, 8'hca);
    ports();
    reset_pin_n = 1'b0;
    i_fcr_host.wt(8);
    reset_pin_n = 1'b1;
    i_fcr_host.wt(8);
    dflt(1'b1);
    rd_all();
    ports();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end
endmodule // testbench
